// file: include/rrs_pkg.sv
package rrs_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PROG_CNT_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int OP_W = 3;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RET_LIT = 3'h1;
  localparam logic [2:0] OP_RETURN = 3'h2;
  localparam logic [2:0] OP_ROT_RIGHT = 3'h3;
  localparam logic [2:0] OP_SLEEP = 3'h4;
  localparam logic [2:0] OP_IRQ_RET = 3'h5;
  localparam logic [2:0] OP_CALL = 3'h6;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam int WDOG_W = 8;
  localparam int PRESC_W = 7;

  typedef enum logic [2:0] {
    RRS_IDLE = 3'b001,
    RRS_FLUSH = 3'b010,
    RRS_ASLEEP = 3'b100
  } rrs_state_t;
endpackage

// file: verilog/rrs_stack.sv
module rrs_stack #(
  parameter int DEPTH = rrs_pkg::STACK_DEPTH,
  parameter int WIDTH = rrs_pkg::PROG_CNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic [WIDTH-1:0] top_o
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
    $error("Stack depth must be power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] ptr_r;

  // Circular: overflow wraps silently, no error flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_r <= '0;
    end else if (push_i) begin
      ptr_r <= ptr_r + 1'b1;
    end else if (pop_i) begin
      ptr_r <= ptr_r - 1'b1; // RQ12
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else if (push_i) begin
      mem_r[PW'(ptr_r + 1'b1)] <= push_data_i;
    end
  end

  assign top_o = mem_r[ptr_r];
endmodule

// file: verilog/rrs_rotate.sv
module rrs_rotate #(
  parameter int WIDTH = rrs_pkg::DATA_W
) (
  input wire logic [WIDTH-1:0] data_i,
  input wire logic carry_i,
  output logic [WIDTH-1:0] result_o,
  output logic carry_o
);
  if (WIDTH < 2) begin : g_width_check
    $error("Rotate width too small");
  end
  assign result_o = {carry_i, data_i[WIDTH-1:1]}; // RQ5
  assign carry_o = data_i[0]; // RQ5
endmodule

// file: verilog/rrs_exec.sv
// How it works
// RQ1 - Return-with-literal loads accumulator with 8-bit literal; flags unchanged.
// RQ2 - Return-with-literal loads program counter from stack top; two cycles.
// RQ3 - Plain return pops stack into program counter; flags untouched.
// RQ4 - Plain return takes two cycles; second refills the fetch.
// RQ5 - Rotate right: old carry into top bit, bit zero into carry.
// RQ6 - Destination bit 0 writes accumulator; 1 writes the file register.
// RQ7 - Sleep clears the power-down flag.
// RQ8 - Sleep sets the watchdog-expiry flag.
// RQ9 - Sleep clears watchdog counter and its prescaler.
// RQ10 - Sleep halts execution and stops oscillator until wake-up.
// RQ11 - Interrupt return loads program counter from stack, sets global enable.
// RQ12 - Each pop moves stack pointer back one entry.
module rrs_exec (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Instruction stream from the decoder, then file read data, watchdog tick and the wake pin
  input wire logic instr_valid_i,
  input wire logic [rrs_pkg::OP_W-1:0] op_i,
  input wire logic [rrs_pkg::DATA_W-1:0] literal_i,
  input wire logic [rrs_pkg::FADDR_W-1:0] file_addr_i,
  input wire logic dest_sel_i,
  input wire logic [rrs_pkg::PROG_CNT_W-1:0] call_target_i,
  input wire logic [rrs_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic wdt_tick_i,
  input wire logic wake_i,
  // Core state driven back to the rest of the core
  output logic busy_o,
  output logic [rrs_pkg::PROG_CNT_W-1:0] program_counter_o,
  output logic [rrs_pkg::DATA_W-1:0] accumulator_o,
  output logic carry_o,
  output logic power_down_flag_o,
  output logic watchdog_expiry_flag_o,
  output logic global_irq_enable_o,
  output logic [rrs_pkg::WDOG_W-1:0] watchdog_counter_o,
  output logic [rrs_pkg::PRESC_W-1:0] watchdog_prescaler_o,
  output logic osc_run_o,
  // File register write-back, one cycle after the rotate
  output logic file_we_o,
  output logic [rrs_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [rrs_pkg::DATA_W-1:0] file_wdata_o
);
  logic rst_sync1_r;
  logic rst_sync2_r;
  logic rst_n;

  logic w1_r;
  logic w2_r;
  logic w3_r;
  logic wake_r;

  rrs_pkg::rrs_state_t state_r;
  logic [rrs_pkg::PROG_CNT_W-1:0] stack_top;
  logic [rrs_pkg::DATA_W-1:0] rot_result;
  logic rot_carry;

  // Decoded strobes, each high only in the cycle an instruction is taken; halt_hold is a level held through sleep
  logic accept;
  logic do_ret_lit;
  logic do_return;
  logic do_irq_ret;
  logic do_rot;
  logic do_sleep;
  logic pop;
  logic push;
  logic halt_hold;

  // Opcode field must hold every code decoded here
  if (rrs_pkg::OP_W < 3) begin : g_op_check
    $error("Opcode field too narrow for the decoded codes");
  end

  // Release reset synchronously to avoid partial-domain recovery
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  // Wake pin is asynchronous: three stages, and the filter below reads the second and the third
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      w1_r <= 1'b0;
      w2_r <= 1'b0;
      w3_r <= 1'b0;
    end else begin
      w1_r <= wake_i;
      w2_r <= w1_r;
      w3_r <= w2_r;
    end
  end

  // Level taken only when stages two and three agree, so a glitch is dropped
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else if (w2_r == w3_r) begin
      wake_r <= w3_r;
    end
  end

  // Single decode point so every process agrees on what was taken
  function automatic logic op_hit(
    input logic taken,
    input logic [rrs_pkg::OP_W-1:0] op,
    input logic [rrs_pkg::OP_W-1:0] code
  );
    return taken && (op == code);
  endfunction

  assign accept = instr_valid_i && (state_r == rrs_pkg::RRS_IDLE);
  assign do_ret_lit = op_hit(accept, op_i, rrs_pkg::OP_RET_LIT);
  assign do_return = op_hit(accept, op_i, rrs_pkg::OP_RETURN);
  assign do_irq_ret = op_hit(accept, op_i, rrs_pkg::OP_IRQ_RET);
  assign do_rot = op_hit(accept, op_i, rrs_pkg::OP_ROT_RIGHT);
  assign do_sleep = op_hit(accept, op_i, rrs_pkg::OP_SLEEP);
  assign push = op_hit(accept, op_i, rrs_pkg::OP_CALL);
  // All three returns unwind the same stack
  assign pop = do_ret_lit || do_return || do_irq_ret; // RQ3
  // Parked in sleep until the filtered wake level is seen
  assign halt_hold = (state_r == rrs_pkg::RRS_ASLEEP) && !wake_r;

  // Call pushes the current count; every return pops it back
  rrs_stack #(
    .DEPTH(rrs_pkg::STACK_DEPTH),
    .WIDTH(rrs_pkg::PROG_CNT_W)
  ) u_stack (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(program_counter_o),
    .top_o(stack_top)
  );

  rrs_rotate #(
    .WIDTH(rrs_pkg::DATA_W)
  ) u_rot (
    .data_i(file_rdata_i),
    .carry_i(carry_o),
    .result_o(rot_result),
    .carry_o(rot_carry)
  );

  // Sequencing: returns spend a flush cycle, sleep parks until wake
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rrs_pkg::RRS_IDLE;
    end else begin
      case (state_r)
        rrs_pkg::RRS_IDLE: begin
          if (pop) begin
            state_r <= rrs_pkg::RRS_FLUSH; // RQ2 RQ4
          end else if (do_sleep) begin
            state_r <= rrs_pkg::RRS_ASLEEP; // RQ10
          end
        end
        rrs_pkg::RRS_FLUSH: begin
          state_r <= rrs_pkg::RRS_IDLE; // RQ4
        end
        rrs_pkg::RRS_ASLEEP: begin
          if (wake_r) begin
            state_r <= rrs_pkg::RRS_IDLE;
          end
        end
        default: state_r <= rrs_pkg::RRS_IDLE;
      endcase
    end
  end

  // Busy covers the flush cycle and the whole sleep
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= pop || do_sleep || halt_hold; // RQ4 RQ10
    end
  end

  // Oscillator gate stays off until the filtered wake arrives
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_o <= 1'b1;
    end else begin
      osc_run_o <= !(do_sleep || halt_hold); // RQ10
    end
  end

  // Program counter: returns take stack top, call takes its target, others advance
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_o <= '0;
    end else if (pop) begin
      program_counter_o <= stack_top; // RQ2 RQ3 RQ11
    end else if (push) begin
      program_counter_o <= call_target_i;
    end else if (accept) begin
      program_counter_o <= program_counter_o + 1'b1;
    end
  end

  // Accumulator: literal return and rotate with destination 0
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_o <= rrs_pkg::ACC_RST;
    end else if (do_ret_lit) begin
      accumulator_o <= literal_i; // RQ1
    end else if (do_rot && !dest_sel_i) begin
      accumulator_o <= rot_result; // RQ6
    end
  end

  // File write-back for destination 1
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= do_rot && dest_sel_i; // RQ6
    end
  end

  // Address and data move only when a write is due, quiet port otherwise
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      file_waddr_o <= '0;
      file_wdata_o <= '0;
    end else if (do_rot && dest_sel_i) begin
      file_waddr_o <= file_addr_i; // RQ6
      file_wdata_o <= rot_result; // RQ5
    end
  end

  // Carry is the only flag rotate touches; returns touch none
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      carry_o <= 1'b0;
    end else if (do_rot) begin
      carry_o <= rot_carry; // RQ5
    end
  end

  // Power-down flag reads 1 after reset; only sleep clears it here
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_down_flag_o <= 1'b1;
    end else if (do_sleep) begin
      power_down_flag_o <= 1'b0; // RQ7
    end
  end

  // Expiry flag reads 1 after reset; the expiry that clears it lives elsewhere
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expiry_flag_o <= 1'b1;
    end else if (do_sleep) begin
      watchdog_expiry_flag_o <= 1'b1; // RQ8
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_o <= 1'b0;
    end else if (do_irq_ret) begin
      global_irq_enable_o <= 1'b1; // RQ11
    end
  end

  // Prescaler counts every tick; sleep clears it with priority over a tick
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_prescaler_o <= '0;
    end else if (do_sleep) begin
      watchdog_prescaler_o <= '0; // RQ9
    end else if (wdt_tick_i) begin
      watchdog_prescaler_o <= watchdog_prescaler_o + 1'b1;
    end
  end

  // Minimal watchdog count so the sleep clear has a visible effect
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter_o <= rrs_pkg::WDOG_CLEAR;
    end else if (do_sleep) begin
      watchdog_counter_o <= rrs_pkg::WDOG_CLEAR; // RQ9
    end else if (wdt_tick_i && (&watchdog_prescaler_o)) begin
      watchdog_counter_o <= watchdog_counter_o + 1'b1;
    end
  end
endmodule

// file: dv/rrs_exec_assertions.sv
module rrs_exec_checker (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic instr_valid_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] literal_i,
  input wire logic [6:0] file_addr_i,
  input wire logic dest_sel_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic busy_o,
  input wire logic carry_o,
  input wire logic power_down_flag_o,
  input wire logic watchdog_expiry_flag_o,
  input wire logic global_irq_enable_o,
  input wire logic [7:0] accumulator_o,
  input wire logic [7:0] watchdog_counter_o,
  input wire logic [6:0] watchdog_prescaler_o,
  input wire logic osc_run_o,
  input wire logic file_we_o,
  input wire logic [6:0] file_waddr_o,
  input wire logic [7:0] file_wdata_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire take = instr_valid_i && !busy_o;
  sequence s_two_cycle;
    busy_o ##1 !busy_o;
  endsequence
  sequence s_flags_kept;
    $stable(carry_o) && $stable(power_down_flag_o) && $stable(watchdog_expiry_flag_o);
  endsequence
  ret_lit_acc_a: assert property (take && op_i == rrs_pkg::OP_RET_LIT |=>
    accumulator_o == $past(literal_i) ##0 s_flags_kept) else $error("literal return failed");
  ret_lit_len_a: assert property (take && op_i == rrs_pkg::OP_RET_LIT |=> s_two_cycle)
    else $error("literal return length wrong");
  return_len_a: assert property (take && op_i == rrs_pkg::OP_RETURN |=> s_two_cycle)
    else $error("return length wrong");
  return_flags_a: assert property (take && op_i == rrs_pkg::OP_RETURN |=> s_flags_kept)
    else $error("return changed flags");
  rot_carry_a: assert property (take && op_i == rrs_pkg::OP_ROT_RIGHT |=>
    carry_o == $past(file_rdata_i[0])) else $error("rotate carry wrong");
  rot_file_a: assert property (take && op_i == rrs_pkg::OP_ROT_RIGHT && dest_sel_i |=>
    file_we_o && file_waddr_o == $past(file_addr_i)
    && file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])}) else $error("rotate to file");
  rot_acc_a: assert property (take && op_i == rrs_pkg::OP_ROT_RIGHT && !dest_sel_i |=>
    !file_we_o && accumulator_o == {$past(carry_o), $past(file_rdata_i[7:1])})
    else $error("rotate to accumulator");
  sleep_flags_a: assert property (take && op_i == rrs_pkg::OP_SLEEP |=>
    !power_down_flag_o && watchdog_expiry_flag_o) else $error("sleep flags wrong");
  sleep_wdt_a: assert property (take && op_i == rrs_pkg::OP_SLEEP |=>
    watchdog_counter_o == 8'h00 && watchdog_prescaler_o == 7'h00) else $error("sleep watchdog");
  sleep_halt_a: assert property (take && op_i == rrs_pkg::OP_SLEEP |=>
    (!osc_run_o && busy_o)[*2]) else $error("sleep did not halt");
  irq_ret_a: assert property (take && op_i == rrs_pkg::OP_IRQ_RET |=>
    global_irq_enable_o) else $error("interrupt return enable");
endmodule

// file: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, reset_n_i = 0, instr_valid_i = 0, dest_sel_i = 0, wdt_tick_i = 0;
  logic wake_i = 0;
  logic [2:0] op_i = 3'h0;
  logic [7:0] literal_i = 8'h00, file_rdata_i = 8'h00;
  logic [6:0] file_addr_i = 7'h00;
  logic [12:0] call_target_i = 13'h0;
  logic busy_o, carry_o, power_down_flag_o, watchdog_expiry_flag_o, global_irq_enable_o;
  logic osc_run_o, file_we_o;
  logic [12:0] program_counter_o;
  logic [7:0] accumulator_o, watchdog_counter_o, file_wdata_o;
  logic [6:0] watchdog_prescaler_o, file_waddr_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  rrs_exec dut (.mclk_i, .reset_n_i, .instr_valid_i, .op_i, .literal_i, .file_addr_i,
    .dest_sel_i, .call_target_i, .file_rdata_i, .wdt_tick_i, .wake_i, .busy_o,
    .program_counter_o, .accumulator_o, .carry_o, .power_down_flag_o, .watchdog_expiry_flag_o,
    .global_irq_enable_o, .watchdog_counter_o, .watchdog_prescaler_o, .osc_run_o, .file_we_o,
    .file_waddr_o, .file_wdata_o);
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Arg feeds literal, file index and call target alike
  task automatic issue(logic [2:0] op, logic [12:0] arg, logic dsel, logic [7:0] rd);
    @(posedge mclk_i);
    op_i <= op;
    literal_i <= arg[7:0];
    file_addr_i <= arg[6:0];
    call_target_i <= arg;
    dest_sel_i <= dsel;
    file_rdata_i <= rd;
    instr_valid_i <= 1'b1;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic flush_done();
    @(posedge mclk_i);
    #1;
    check("busy", busy_o, 1'b0);
  endtask
  task automatic t_returns();
    issue(rrs_pkg::OP_CALL, 13'h123, 0, 8'h00);
    issue(rrs_pkg::OP_CALL, 13'h0a5, 0, 8'h00);
    issue(rrs_pkg::OP_RETURN, 13'h000, 0, 8'h00);
    check("program_counter", program_counter_o, 13'h123);
    check("busy", busy_o, 1'b1);
    check("power_down_flag", power_down_flag_o, 1'b1);
    flush_done();
    issue(rrs_pkg::OP_RET_LIT, 13'h0ff, 0, 8'h00);
    check("acc", accumulator_o, 8'hff);
    check("program_counter", program_counter_o, 13'h000);
    check("carry", carry_o, 1'b0);
    flush_done();
  endtask
  task automatic t_rotate();
    issue(rrs_pkg::OP_ROT_RIGHT, 13'h07f, 0, 8'h81);
    check("acc", accumulator_o, 8'h40);
    check("carry", carry_o, 1'b1);
    check("we", file_we_o, 1'b0);
    issue(rrs_pkg::OP_ROT_RIGHT, 13'h055, 1, 8'h02);
    check("wdata", file_wdata_o, 8'h81);
    check("waddr", file_waddr_o, 7'h55);
    check("we", file_we_o, 1'b1);
    check("carry", carry_o, 1'b0);
    check("acc", accumulator_o, 8'h40);
    check("watchdog_expiry_flag", watchdog_expiry_flag_o, 1'b1);
  endtask
  task automatic t_irq();
    issue(rrs_pkg::OP_CALL, 13'h1ff, 0, 8'h00);
    issue(rrs_pkg::OP_IRQ_RET, 13'h000, 0, 8'h00);
    check("program_counter", program_counter_o, 13'h002);
    check("global_irq_enable", global_irq_enable_o, 1'b1);
    flush_done();
  endtask
  task automatic t_sleep();
    @(posedge mclk_i);
    wdt_tick_i <= 1'b1;
    // Enough ticks to carry the prescaler once, so both clears are visible
    repeat (130) @(posedge mclk_i);
    wdt_tick_i <= 1'b0;
    #1;
    check("watchdog_counter", watchdog_counter_o, 8'h01);
    check("presc", watchdog_prescaler_o, 7'h02);
    issue(rrs_pkg::OP_SLEEP, 13'h000, 0, 8'h00);
    check("power_down_flag", power_down_flag_o, 1'b0);
    check("watchdog_expiry_flag", watchdog_expiry_flag_o, 1'b1);
    check("watchdog_counter", watchdog_counter_o, 8'h00);
    check("presc", watchdog_prescaler_o, 7'h00);
    check("osc_run", osc_run_o, 1'b0);
    issue(rrs_pkg::OP_CALL, 13'h0aa, 0, 8'h00);
    check("program_counter", program_counter_o, 13'h003);
    check("busy", busy_o, 1'b1);
    @(posedge mclk_i);
    wake_i <= 1'b1;
    // Three sync stages plus the agreement stage, then the state edge
    repeat (4) @(posedge mclk_i);
    #1;
    check("busy", busy_o, 1'b1);
    check("osc_run", osc_run_o, 1'b0);
    @(posedge mclk_i);
    #1;
    check("busy", busy_o, 1'b0);
    check("osc_run", osc_run_o, 1'b1);
    @(posedge mclk_i);
    wake_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    check("power_down_flag", power_down_flag_o, 1'b1);
    check("osc_run", osc_run_o, 1'b1);
    t_returns();
    t_rotate();
    t_irq();
    t_sleep();
    print_verdict();
  end
endmodule
bind rrs_exec rrs_exec_checker chk (.mclk_i, .reset_n_i, .instr_valid_i, .op_i, .literal_i,
  .file_addr_i, .dest_sel_i, .file_rdata_i, .busy_o, .carry_o, .power_down_flag_o,
  .watchdog_expiry_flag_o, .global_irq_enable_o, .accumulator_o, .watchdog_counter_o,
  .watchdog_prescaler_o, .osc_run_o, .file_we_o, .file_waddr_o, .file_wdata_o);
